// ==== src/pia_pkg.sv ====
package pia_pkg;
    localparam logic [4:0] ADDR_ID_LOW = 5'h03;
    localparam logic [4:0] ADDR_ADV = 5'h04;
    localparam int ID_OUI_LSB = 10;
    localparam int ID_MODEL_LSB = 4;
    localparam int ID_REV_LSB = 0;
    localparam logic [15:0] ADV_NOMINAL = 16'h01E1;
    localparam int ADV_NP = 15;
    localparam int ADV_RSVD = 14;
    localparam int ADV_RF = 13;
    localparam int ADV_XNP = 12;
    localparam int ADV_APAUSE = 11;
    localparam int ADV_PAUSE = 10;
    localparam int ADV_T4 = 9;
    localparam int ADV_TECH_LSB = 5;
    localparam logic [4:0] SELECTOR_VAL = 5'h01;
    localparam logic [15:0] ADV_WR_MASK = 16'hBDE0;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pia_req_type;

    typedef struct packed {
        logic       valid;
        logic [15:0] rdata;
    } pia_rsp_type;

    typedef enum logic [1:0] {
        PIA_IDLE = 2'b00,
        PIA_STRAP = 2'b01,
        PIA_RUN = 2'b10
    } pia_state_type;
endpackage

// ==== src/pia_regs.sv ====
`timescale 1ns/1ns
module pia_regs #(
    parameter logic [5:0] OUI_BITS = 6'h15,   // arbitrary value
    parameter logic [5:0] MODEL_NUM = 6'h05,  // arbitrary value
    parameter logic [3:0] DEVICE_REVISION_FIELD = 4'h1      // arbitrary value
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    // strap inputs: high forbids the offer
    input wire logic [3:0] I_STRAP_TECH_OFF,
    // management access
    input wire pia_pkg::pia_req_type I_REQ,
    output pia_pkg::pia_rsp_type O_RSP,
    // advertised word toward negotiation engine
    output logic [15:0] O_ADV_WORD
);
    pia_pkg::pia_state_type state_r;
    pia_pkg::pia_state_type state_nxt;
    logic [15:0] adv_r;
    logic [15:0] adv_nxt;
    pia_pkg::pia_rsp_type rsp_r;
    pia_pkg::pia_rsp_type rsp_nxt;
    wire logic [15:0] id_word;
    wire logic [15:0] adv_strapped;
    wire logic [15:0] adv_written;
    wire logic [15:0] rd_word;
    wire logic hit_adv;

    function automatic logic [15:0] fix_adv(input logic [15:0] v);
        logic [15:0] r;
        r = v & pia_pkg::ADV_WR_MASK;
        r[pia_pkg::ADV_RSVD] = 1'b0;
        r[pia_pkg::ADV_T4] = 1'b0;
        r[4:0] = pia_pkg::SELECTOR_VAL;
        return r;
    endfunction

    assign id_word = {OUI_BITS, MODEL_NUM, DEVICE_REVISION_FIELD};
    // straps are applied on the second enabled edge after reset release, never inside reset
    assign adv_strapped = fix_adv({pia_pkg::ADV_NOMINAL[15:9],
        pia_pkg::ADV_NOMINAL[8:5] & ~I_STRAP_TECH_OFF, 5'h00});
    // next page, fault, ext pages, pause and tech bits are writable
    assign adv_written = fix_adv(I_REQ.wdata);
    assign hit_adv = I_REQ.wr && (I_REQ.addr == pia_pkg::ADDR_ADV);
    assign rd_word = (I_REQ.addr == pia_pkg::ADDR_ID_LOW) ? id_word :
                     (I_REQ.addr == pia_pkg::ADDR_ADV) ? adv_r : 16'h0000;

    always_comb begin
        state_nxt = state_r;
        adv_nxt = adv_r;
        rsp_nxt.valid = 1'b0;
        rsp_nxt.rdata = rsp_r.rdata;
        case (state_r)
            pia_pkg::PIA_IDLE: begin
                state_nxt = pia_pkg::PIA_STRAP;
            end
            pia_pkg::PIA_STRAP: begin
                adv_nxt = adv_strapped;
                state_nxt = pia_pkg::PIA_RUN;
            end
            pia_pkg::PIA_RUN: begin
                if (hit_adv) begin
                    adv_nxt = adv_written;
                end
                if (I_REQ.rd) begin
                    rsp_nxt.valid = 1'b1;
                    rsp_nxt.rdata = rd_word;
                end
            end
            default: begin
                state_nxt = pia_pkg::PIA_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_r <= pia_pkg::PIA_IDLE;
            adv_r <= pia_pkg::ADV_NOMINAL;
            rsp_r <= '0;
        end else if (I_CE) begin
            state_r <= state_nxt;
            adv_r <= adv_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    assign O_RSP = rsp_r;
    assign O_ADV_WORD = adv_r;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence s_adv_write;
        I_CE && state_r == pia_pkg::PIA_RUN && hit_adv;
    endsequence

    sequence s_read_req;
        I_CE && state_r == pia_pkg::PIA_RUN && I_REQ.rd;
    endsequence

    // read path: answer one cycle after the taking edge
    a_id_read_word: assert property (
        s_read_req ##0 (I_REQ.addr == pia_pkg::ADDR_ID_LOW)
        |=> O_RSP.valid && O_RSP.rdata == id_word)
        else $error("identifier read wrong");

    a_adv_read_word: assert property (
        s_read_req ##0 (I_REQ.addr == pia_pkg::ADDR_ADV)
        |=> O_RSP.valid && O_RSP.rdata == $past(adv_r))
        else $error("advert read wrong");

    a_unmapped_read: assert property (
        s_read_req ##0 (I_REQ.addr != pia_pkg::ADDR_ID_LOW && I_REQ.addr != pia_pkg::ADDR_ADV)
        |=> O_RSP.valid && O_RSP.rdata == 16'h0000)
        else $error("unmapped read not zero");

    a_no_read_quiet: assert property (
        I_CE && !(state_r == pia_pkg::PIA_RUN && I_REQ.rd)
        |=> !O_RSP.valid)
        else $error("answer without read");

    a_rdata_hold: assert property (
        I_CE && !(state_r == pia_pkg::PIA_RUN && I_REQ.rd)
        |=> $stable(O_RSP.rdata))
        else $error("read data moved without read");

    // start-up order: straps land before any request is honoured
    a_boot_strap: assert property (
        I_CE && state_r == pia_pkg::PIA_IDLE
        |=> state_r == pia_pkg::PIA_STRAP)
        else $error("idle did not step to strap");

    a_strap_run: assert property (
        I_CE && state_r == pia_pkg::PIA_STRAP
        |=> state_r == pia_pkg::PIA_RUN)
        else $error("strap did not step to run");

    a_run_stays: assert property (
        I_CE && state_r == pia_pkg::PIA_RUN
        |=> state_r == pia_pkg::PIA_RUN)
        else $error("run state left");

    a_strap_load: assert property (
        I_CE && state_r == pia_pkg::PIA_STRAP
        |=> adv_r[8:5] == (4'hF & ~$past(I_STRAP_TECH_OFF)))
        else $error("strap load wrong");

    a_strap_fixed: assert property (
        I_CE && state_r == pia_pkg::PIA_STRAP
        |=> adv_r[15:9] == 7'h00 && adv_r[4:0] == pia_pkg::SELECTOR_VAL)
        else $error("strap load upper or selector wrong");

    a_early_ignored: assert property (
        I_CE && state_r == pia_pkg::PIA_IDLE
        |=> $stable(adv_r))
        else $error("write taken before strap");

    // write path: writable bits follow the data word
    a_np_write: assert property (
        s_adv_write
        |=> adv_r[15] == $past(I_REQ.wdata[15]))
        else $error("next page not written");

    a_rf_write: assert property (
        s_adv_write
        |=> adv_r[13] == $past(I_REQ.wdata[13]))
        else $error("fault flag not written");

    a_xnp_write: assert property (
        s_adv_write
        |=> adv_r[12] == $past(I_REQ.wdata[12]))
        else $error("ext page flag not written");

    a_pause_write: assert property (
        s_adv_write
        |=> adv_r[11:10] == $past(I_REQ.wdata[11:10]))
        else $error("pause bits not written");

    a_t4_zero: assert property (
        state_r == pia_pkg::PIA_RUN
        |-> adv_r[9] == 1'b0)
        else $error("four pair bit set");

    a_t4_write: assert property (
        s_adv_write
        |=> adv_r[9] == 1'b0)
        else $error("four pair bit written");

    a_tech_write: assert property (
        s_adv_write
        |=> adv_r[8:5] == $past(I_REQ.wdata[8:5]))
        else $error("tech bits not written");

    a_sel_fixed: assert property (
        1'b1
        |-> adv_r[4:0] == pia_pkg::SELECTOR_VAL)
        else $error("selector changed");

    a_sel_write: assert property (
        s_adv_write
        |=> adv_r[4:0] == pia_pkg::SELECTOR_VAL)
        else $error("selector written");

    a_rsvd_fixed: assert property (
        s_adv_write
        |=> adv_r[14] == 1'b0)
        else $error("reserved bit written");

    a_no_write_hold: assert property (
        I_CE && state_r == pia_pkg::PIA_RUN && !hit_adv
        |=> $stable(adv_r))
        else $error("advert changed without write");

    // a low enable must freeze everything, requests included
    a_ce_freeze: assert property (
        !I_CE
        |=> $stable(adv_r) && $stable(state_r) && $stable(rsp_r))
        else $error("state moved while enable low");
endmodule

// ==== dv/pia_host.sv ====
`timescale 1ns/1ns
module pia_host (
    // clock
    input wire logic i_clk,
    // management access
    input wire pia_pkg::pia_rsp_type i_rsp,
    output pia_pkg::pia_req_type o_req
);
    logic seen_valid = 1'b0;
    initial o_req = '0;
    // one request, then idle so the answer is never mixed with the next request
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge i_clk);
        o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_clk);
        o_req <= '0;
        #1 seen_valid = i_rsp.valid;
        @(posedge i_clk);
        #1 q = i_rsp.rdata;
    endtask
endmodule

// ==== dv/pia_regs_bench.sv ====
`timescale 1ns/1ns
module pia_regs_bench;
    logic clk = 0;
    logic rst_n = 0;
    logic ce = 1;
    logic [3:0] strap = 4'h0;
    pia_pkg::pia_req_type req;
    pia_pkg::pia_rsp_type rsp;
    logic [15:0] adv, q;
    int miscompares = 0, total_checks = 0, cycles = 0;
    pia_regs i_pia_regs (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_STRAP_TECH_OFF(strap),
        .I_REQ(req), .O_RSP(rsp), .O_ADV_WORD(adv));
    pia_host i_pia_host (.i_clk(clk), .i_rsp(rsp), .o_req(req));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // a hang past this many cycles is a fault; the whole run needs about 48
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic do_reset(input logic [3:0] s);
        @(posedge clk);
        rst_n <= 0;
        strap <= s;
        repeat (2) @(posedge clk);
        chk("adv in reset", 16'h01E1, adv);
        rst_n <= 1;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_defaults();
        do_reset(4'h0);
        i_pia_host.xfer(0, pia_pkg::ADDR_ADV, 16'h0, q);
        chk("adv reset", 16'h01E1, q);
        i_pia_host.xfer(0, pia_pkg::ADDR_ID_LOW, 16'h0, q);
        chk("id", {6'h15, 6'h05, 4'h1}, q);
        chk("read valid", 16'h0001, {15'h0000, i_pia_host.seen_valid});
        i_pia_host.xfer(1, pia_pkg::ADDR_ID_LOW, 16'hFFFF, q);
        i_pia_host.xfer(0, pia_pkg::ADDR_ID_LOW, 16'h0, q);
        chk("id kept", {6'h15, 6'h05, 4'h1}, q);
        i_pia_host.xfer(0, 5'h05, 16'h0, q);
        chk("unmapped", 16'h0000, q);
    endtask
    task automatic t_writes();
        i_pia_host.xfer(1, pia_pkg::ADDR_ADV, 16'hFFFF, q);
        chk("adv word", 16'hBDE1, adv);
        chk("write no valid", 16'h0000, {15'h0000, i_pia_host.seen_valid});
        i_pia_host.xfer(0, pia_pkg::ADDR_ADV, 16'h0, q);
        chk("adv ones", 16'hBDE1, q);
        i_pia_host.xfer(1, pia_pkg::ADDR_ADV, 16'h0000, q);
        i_pia_host.xfer(0, pia_pkg::ADDR_ADV, 16'h0, q);
        chk("adv zeros", 16'h0001, q);
    endtask
    // a write while the enable is low must be lost
    task automatic t_freeze();
        @(posedge clk);
        ce <= 0;
        i_pia_host.xfer(1, pia_pkg::ADDR_ADV, 16'h8400, q);
        chk("adv frozen", 16'h0001, adv);
        @(posedge clk);
        ce <= 1;
        i_pia_host.xfer(1, pia_pkg::ADDR_ADV, 16'h8400, q);
        chk("adv after freeze", 16'h8401, adv);
    endtask
    // straps clear bits 8 and 6 of the nominal word
    task automatic t_strap();
        do_reset(4'hA);
        i_pia_host.xfer(0, pia_pkg::ADDR_ADV, 16'h0, q);
        chk("adv strapped", 16'h00A1, q);
    endtask
    initial begin
        t_defaults();
        t_writes();
        t_freeze();
        t_strap();
        conclude();
    end
endmodule
